// ===== fsw_pkg.sv
// Shared constants for the fail-safe watchdog unit: register map,
// field positions, reset values and timing counts.
// Assumes a 100 MHz pclk that also stands in for the oscillator clock.
package fsw_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] FSW_CTRL_OFS   = 8'h00;
  localparam logic [7:0] FSW_RELOAD_OFS = 8'h04;
  localparam logic [7:0] FSW_STATUS_OFS = 8'h08;
  localparam logic [7:0] FSW_COUNT_OFS  = 8'h0C;
  localparam logic [7:0] FSW_IRQST_OFS  = 8'h10;
  localparam logic [7:0] FSW_IRQMSK_OFS = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_REFRESH_BIT = 0;  // refresh_request_bit
  localparam int CTRL_START_BIT   = 1;  // watchdog_start_bit
  localparam int CTRL_SLOW_BIT    = 2;  // 1: divide by 192, 0: by 12
  localparam int STAT_CAUSE_BIT   = 0;  // watchdog_reset_cause_flag
  localparam int STAT_RUN_BIT     = 1;
  localparam int STAT_OSCRST_BIT  = 2;
  localparam int STAT_RCSEL_BIT   = 3;
  localparam int IRQ_WDT_BIT      = 0;
  localparam int IRQ_OSCFAIL_BIT  = 1;
  localparam int IRQ_OSCOK_BIT    = 2;
  localparam int IRQ_W            = 3;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int CNT_W    = 15;
  localparam int RELOAD_W = 7;
  localparam logic [RELOAD_W-1:0] RELOAD_RST = 7'h00;
  localparam logic [IRQ_W-1:0]    MASK_RST   = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int DIV_FAST       = 12;
  localparam int DIV_SLOW       = 192;
  localparam int CLK_MHZ        = 100;
  localparam int SETTLE_TIME_US = 1000;
  localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_MHZ;

endpackage

// ===== fsw_prescaler.sv
// Count-rate prescaler for the watchdog: one tick every 12 or 192 clocks.
// Assumes pclk is the oscillator clock; run low freezes the divider.
`timescale 1ns/1ps
module fsw_prescaler
  import fsw_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic sel_slow,
  output logic      tick_q
);

  logic [7:0] div_q;
  logic [7:0] div_d;
  logic       tick_d;
  logic [7:0] last;

  // Divider next state; frozen rather than cleared so a pause loses nothing
  always_comb begin
    last   = sel_slow ? 8'(DIV_SLOW - 1) : 8'(DIV_FAST - 1);
    div_d  = div_q;
    tick_d = 1'b0;
    if (run) begin
      if (div_q >= last) begin
        div_d  = 8'h00;
        tick_d = 1'b1;
      end else begin
        div_d = div_q + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> !tick_q [*8]) else $error("prescaler ticks too close");

endmodule

// ===== fsw_osc_monitor.sv
// Oscillator monitor: holds reset and selects the RC clock while the
// main oscillator is slow outside power-down and wake-up, then settles before releasing.
// Assumes osc_slow comes from an analogue comparator, async to pclk.
`timescale 1ns/1ps
module fsw_osc_monitor
  import fsw_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic osc_slow,
  input  wire logic power_down,
  output logic      osc_rst_q,
  output logic      rc_sel_q,
  output logic      hold_q,
  output logic      fail_evt_q,
  output logic      ok_evt_q
);

  typedef enum logic [2:0] {
    MON_POWERON,
    MON_FAIL,
    MON_SETTLE,
    MON_RUN,
    MON_PDOWN,
    MON_WAKE
  } fsw_mon_t;

  fsw_mon_t    st_q, st_d;
  logic [16:0] cnt_q, cnt_d;
  logic        sync1_q, slow_q;
  logic        osc_rst_d, rc_sel_d, hold_d, fail_d, ok_d;

  // Two-stage synchroniser for the comparator level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b1;
      slow_q  <= 1'b1;
    end else begin
      sync1_q <= osc_slow;
      slow_q  <= sync1_q;
    end
  end

  // Monitor sequence; power-on starts from the RC clock, as after a failure
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    fail_d = 1'b0;
    ok_d   = 1'b0;
    case (st_q)
      MON_POWERON, MON_FAIL: begin
        if (!slow_q) begin
          st_d  = MON_SETTLE;
          cnt_d = 17'(SETTLE - 1);
        end
      end
      MON_SETTLE: begin
        if (slow_q) begin
          st_d   = MON_FAIL;
          fail_d = 1'b1;
        end else if (cnt_q == 17'h00000) begin
          st_d = MON_RUN;
          ok_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 17'h00001;
        end
      end
      MON_RUN: begin
        if (power_down) begin
          st_d = MON_PDOWN;
        end else if (slow_q) begin
          st_d   = MON_FAIL;
          fail_d = 1'b1;
        end
      end
      MON_PDOWN: begin
        if (!power_down) begin
          st_d = MON_WAKE;
        end
      end
      MON_WAKE: begin
        if (!slow_q) begin
          if (cnt_q == 17'h00000) begin
            st_d = MON_RUN;
          end else begin
            cnt_d = cnt_q - 17'h00001;
          end
        end else begin
          cnt_d = 17'(SETTLE - 1);
        end
      end
      default: st_d = MON_POWERON;
    endcase
    if (st_q != MON_WAKE && st_d == MON_WAKE) begin
      cnt_d = 17'(SETTLE - 1);
    end
    osc_rst_d = (st_d == MON_POWERON) || (st_d == MON_FAIL) || (st_d == MON_SETTLE);
    rc_sel_d  = (st_d == MON_POWERON) || (st_d == MON_FAIL);
    hold_d    = (st_d == MON_WAKE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= MON_POWERON;
      cnt_q      <= 17'h00000;
      osc_rst_q  <= 1'b1;
      rc_sel_q   <= 1'b1;
      hold_q     <= 1'b0;
      fail_evt_q <= 1'b0;
      ok_evt_q   <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      osc_rst_q  <= osc_rst_d;
      rc_sel_q   <= rc_sel_d;
      hold_q     <= hold_d;
      fail_evt_q <= fail_d;
      ok_evt_q   <= ok_d;
    end
  end

  chk_fail_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == MON_RUN && slow_q && !power_down) |=> osc_rst_q && rc_sel_q)
    else $error("slow oscillator did not force reset");
  chk_settle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == MON_SETTLE && cnt_q != 17'h00000 && !slow_q) |=> osc_rst_q && !rc_sel_q)
    else $error("reset released before settling");
  chk_wake_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == MON_PDOWN && !power_down) |=> hold_q)
    else $error("wake-up did not wait for settling");

endmodule

// ===== fsw_watchdog.sv
// Fail-safe watchdog unit: 15-bit programmable watchdog timer plus
// oscillator monitor, with an APB register slave and one interrupt.
// Assumes pclk is the oscillator clock; idle and power-down come from
// the CPU on pclk; the start pin and comparator are asynchronous.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fsw_watchdog
  import fsw_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hardware_watchdog_start_pin,
  input  wire logic        idle_mode,
  input  wire logic        power_down,
  input  wire logic        osc_slow,
  output logic             wdt_reset_q,
  output logic             osc_reset,
  output logic             rc_clk_sel,
  output logic             wake_hold,
  output logic             irq_q
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0]         prdata_q, prdata_d;
  logic                pready_q, pready_d;
  logic                pslverr_q, pslverr_d;
  logic [CNT_W-1:0]    cnt_q, cnt_d;
  logic [RELOAD_W-1:0] watchdog_reload_value_q, reload_d;
  logic                running_q, running_d;
  logic                sel_slow_q, sel_slow_d;
  logic                armed_q, armed_d;
  logic                cause_q, cause_d;
  logic                wdt_reset_d;
  logic [IRQ_W-1:0]    irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0]    irq_mask_q, irq_mask_d;
  logic                irq_d;
  logic                pin_s1_q, pin_q;
  logic                tick;
  logic                frozen;
  logic                wr_done, rd_setup, xfer_done;
  logic                refresh_hit, ovf;
  logic                arm_wr;
  logic                cnt_step;
  logic                mon_rst, mon_rcsel, mon_hold, mon_fail, mon_ok;

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  // Prescaler pauses with the timer, so a pause loses at most the one tick already in flight
  fsw_prescaler u_presc (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (running_q && !frozen),
    .sel_slow (sel_slow_q),
    .tick_q   (tick)
  );

  // Monitor supervises the clock whether or not the timer runs
  fsw_osc_monitor #(.SETTLE(SETTLE)) u_mon (
    .pclk       (pclk),
    .presetn    (presetn),
    .osc_slow   (osc_slow),
    .power_down (power_down),
    .osc_rst_q  (mon_rst),
    .rc_sel_q   (mon_rcsel),
    .hold_q     (mon_hold),
    .fail_evt_q (mon_fail),
    .ok_evt_q   (mon_ok)
  );

  // Monitor levels already leave its own flops
  assign osc_reset  = mon_rst;
  assign rc_clk_sel = mon_rcsel;
  assign wake_hold  = mon_hold;
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;

  // Start pin is asynchronous: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 1'b0;
      pin_q    <= 1'b0;
    end else begin
      pin_s1_q <= hardware_watchdog_start_pin;
      pin_q    <= pin_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: one wait state, so pready comes from a flop
  // ---------------------------------------------------------------
  // CTRL: refresh request, start, slow rate; RELOAD: counter bits 14..8
  // STATUS: cause, running, monitor reset, RC clock; COUNT: live value
  // IRQ status (write one to clear) and mask; upper bits read zero
  // Unmapped words read zero and answer with pslverr
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == FSW_CTRL_OFS) || (a == FSW_RELOAD_OFS) ||
             (a == FSW_STATUS_OFS) || (a == FSW_COUNT_OFS) ||
             (a == FSW_IRQST_OFS) || (a == FSW_IRQMSK_OFS);
  endfunction

  // First access edge books the answer, the second completes it
  assign rd_setup  = psel && penable && !pready_q;
  assign xfer_done = psel && penable && pready_q;
  assign wr_done   = xfer_done && pwrite && mapped(paddr);

  // Bus handshake and read data
  always_comb begin
    pready_d  = rd_setup;
    pslverr_d = rd_setup && !mapped(paddr);
    prdata_d  = 32'h00000000;
    if (rd_setup && !pwrite) begin
      case (paddr)
        FSW_CTRL_OFS:   prdata_d[CTRL_SLOW_BIT] = sel_slow_q;
        FSW_RELOAD_OFS: prdata_d[RELOAD_W-1:0] = watchdog_reload_value_q;
        FSW_STATUS_OFS: begin
          prdata_d[STAT_CAUSE_BIT]  = cause_q;
          prdata_d[STAT_RUN_BIT]    = running_q;
          prdata_d[STAT_OSCRST_BIT] = mon_rst;
          prdata_d[STAT_RCSEL_BIT]  = mon_rcsel;
        end
        FSW_COUNT_OFS:  prdata_d[CNT_W-1:0] = cnt_q;
        FSW_IRQST_OFS:  prdata_d[IRQ_W-1:0] = irq_stat_q;
        FSW_IRQMSK_OFS: prdata_d[IRQ_W-1:0] = irq_mask_q;
        default:        prdata_d = 32'h00000000;
      endcase
    end
  end

  // Answer flops: pready, pslverr and read data stand one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog timer
  // ---------------------------------------------------------------
  // Idle and power-down pause the timer without clearing it
  assign frozen = idle_mode || power_down;
  // A tick already in flight as the CPU sleeps is dropped, not deferred
  assign cnt_step = running_q && tick && !frozen;

  // Refresh request alone arms; both bits in one write start without arming
  assign arm_wr = wr_done && (paddr == FSW_CTRL_OFS) &&
                  pwdata[CTRL_REFRESH_BIT] && !pwdata[CTRL_START_BIT];
  // Refresh only when the transfer right after the arming write sets start
  assign refresh_hit = armed_q && wr_done && (paddr == FSW_CTRL_OFS) &&
                       pwdata[CTRL_START_BIT];

  // Overflow only on a real step from the top count
  assign ovf = cnt_step && (cnt_q == {CNT_W{1'b1}}) && !refresh_hit;

  // Counter, start, refresh sequence and reset cause
  always_comb begin
    cnt_d       = cnt_q;
    running_d   = running_q;
    reload_d    = watchdog_reload_value_q;
    sel_slow_d  = sel_slow_q;
    armed_d     = armed_q;
    cause_d     = cause_q;
    wdt_reset_d = 1'b0;
    // Any completed transfer ends an armed sequence, the hit included, unless it is another arming write
    if (xfer_done) begin
      armed_d = 1'b0;
    end
    if (wr_done && paddr == FSW_CTRL_OFS) begin
      if (arm_wr) begin
        armed_d = 1'b1;
      end
      if (pwdata[CTRL_START_BIT]) begin
        running_d = 1'b1;
      end
      // Rate may only change while stopped, so a running period is fixed
      if (!running_q) begin
        sel_slow_d = pwdata[CTRL_SLOW_BIT];
      end
    end
    if (wr_done && paddr == FSW_RELOAD_OFS) begin
      reload_d = pwdata[RELOAD_W-1:0];
    end
    if (pin_q) begin
      running_d = 1'b1;
    end
    if (refresh_hit) begin
      cnt_d = {watchdog_reload_value_q, {(CNT_W-RELOAD_W){1'b0}}};
    end else if (ovf) begin
      // Internal reset: counter cleared, timer stopped, cause recorded
      cnt_d       = {CNT_W{1'b0}};
      running_d   = 1'b0;
      cause_d     = 1'b1;
      wdt_reset_d = 1'b1;
    end else if (cnt_step) begin
      cnt_d = cnt_q + 15'h0001;
    end
  end

  // External reset clears the counter and leaves the timer stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q                   <= {CNT_W{1'b0}};
      running_q               <= 1'b0;
      watchdog_reload_value_q <= RELOAD_RST;
      sel_slow_q              <= 1'b0;
      armed_q                 <= 1'b0;
      cause_q                 <= 1'b0;
      wdt_reset_q             <= 1'b0;
    end else begin
      cnt_q                   <= cnt_d;
      running_q               <= running_d;
      watchdog_reload_value_q <= reload_d;
      sel_slow_q              <= sel_slow_d;
      armed_q                 <= armed_d;
      cause_q                 <= cause_d;
      wdt_reset_q             <= wdt_reset_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: sticky status, set wins over write-one-to-clear
  // ---------------------------------------------------------------
  always_comb begin
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (wr_done && paddr == FSW_IRQST_OFS) begin
      irq_stat_d = irq_stat_q & ~pwdata[IRQ_W-1:0];
    end
    if (wr_done && paddr == FSW_IRQMSK_OFS) begin
      irq_mask_d = pwdata[IRQ_W-1:0];
    end
    irq_stat_d[IRQ_WDT_BIT]     = irq_stat_d[IRQ_WDT_BIT] | ovf;
    irq_stat_d[IRQ_OSCFAIL_BIT] = irq_stat_d[IRQ_OSCFAIL_BIT] | mon_fail;
    irq_stat_d[IRQ_OSCOK_BIT]   = irq_stat_d[IRQ_OSCOK_BIT] | mon_ok;
    // Registered below, so the pin lags the status by one cycle
    irq_d = |(irq_stat_q & irq_mask_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= {IRQ_W{1'b0}};
      irq_mask_q <= MASK_RST;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Counter, refresh and overflow
  chk_refresh_load: assert property (@(posedge pclk) disable iff (!presetn)
    refresh_hit |=> cnt_q == {$past(watchdog_reload_value_q), 8'h00})
    else $error("refresh did not load reload value");

  chk_overflow_reset: assert property (@(posedge pclk) disable iff (!presetn)
    ovf |=> wdt_reset_q && cause_q && !running_q && cnt_q == 15'h0000)
    else $error("overflow did not reset");

  chk_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ovf |=> irq_stat_q[IRQ_WDT_BIT])
    else $error("overflow event lost");

  // Start, freeze and refresh sequence
  chk_no_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (running_q && !ovf) |=> running_q)
    else $error("running watchdog stopped");

  chk_pin_start: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_q && !ovf) |=> running_q)
    else $error("start pin ignored");

  chk_freeze_count: assert property (@(posedge pclk) disable iff (!presetn)
    (frozen && !refresh_hit) |=> $stable(cnt_q))
    else $error("counter moved while frozen");

  chk_broken_seq: assert property (@(posedge pclk) disable iff (!presetn)
    (armed_q && xfer_done && !refresh_hit && !arm_wr) |=>
      !armed_q && (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + 15'h0001 || wdt_reset_q))
    else $error("broken refresh sequence not discarded");

  chk_hit_disarms: assert property (@(posedge pclk) disable iff (!presetn)
    refresh_hit |=> !armed_q)
    else $error("refresh left the sequence armed");

  chk_needs_arm: assert property (@(posedge pclk) disable iff (!presetn)
    (!armed_q && running_q && tick && cnt_q != 15'h7FFF && !frozen) |=>
      cnt_q == $past(cnt_q) + 15'h0001)
    else $error("count changed without valid sequence");

  // Registers and bus
  chk_cause_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    cause_q |=> cause_q)
    else $error("reset cause flag lost");

  chk_reload_top: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && paddr == FSW_RELOAD_OFS) |=> watchdog_reload_value_q == $past(pwdata[6:0]))
    else $error("reload value not stored");

  chk_rate_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (running_q && wr_done && paddr == FSW_CTRL_OFS) |=> $stable(sel_slow_q))
    else $error("count rate changed while running");

  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q |=> !pready_q)
    else $error("pready stood longer than one cycle");

endmodule

// ===== testbench.sv
// Self-checking testbench for the fail-safe watchdog unit.
// Assumes fsw_watchdog with its own assertions; 100 MHz pclk, APB master.
`timescale 1ns/1ps
module testbench;
  import fsw_pkg::*;

  // ------------------------------------------------------------
  // Signals and design instance
  // ------------------------------------------------------------
  localparam int SET = 20;  // Short settle keeps the run brief
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        idle_mode;
  logic        power_down;
  logic        osc_slow;
  logic        wdt_reset_q;
  logic        osc_reset;
  logic        rc_clk_sel;
  logic        wake_hold;
  logic        irq_q;
  int          bad_count;
  int          checked;

  fsw_watchdog #(.SETTLE(SET)) fsw_watchdog_inst (
    .pclk                        (pclk),
    .presetn                     (presetn),
    .psel                        (psel),
    .penable                     (penable),
    .pwrite                      (pwrite),
    .paddr                       (paddr),
    .pwdata                      (pwdata),
    .prdata                      (prdata),
    .pready                      (pready),
    .pslverr                     (pslverr),
    .hardware_watchdog_start_pin (pin),
    .idle_mode                   (idle_mode),
    .power_down                  (power_down),
    .osc_slow                    (osc_slow),
    .wdt_reset_q                 (wdt_reset_q),
    .osc_reset                   (osc_reset),
    .rc_clk_sel                  (rc_clk_sel),
    .wake_hold                   (wake_hold),
    .irq_q                       (irq_q)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Single exit point of the run
  task automatic print_verdict;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for a level; running out ends the run
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (s !== v) begin
      bad_count++;
      $display("FAIL t=%0t wait timed out", $time);
      print_verdict();
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      bad_count++;
      $display("FAIL t=%0t no pready", $time);
      print_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // Read COUNT twice, cyc clocks apart; return the advance
  task automatic rate(input int cyc, output logic [31:0] d);
    logic [31:0] a;
    logic [31:0] b;
    rd(FSW_COUNT_OFS, a);
    repeat (cyc) @(posedge pclk);
    rd(FSW_COUNT_OFS, b);
    d = b - a;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic do_reset;
    int n;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    check({30'h0, osc_reset, rc_clk_sel}, 32'h3, "reset on rc clock");
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    check({31'h0, osc_reset}, 32'h1, "power-on hold");
    wait_lvl(osc_reset, 1'b0, 4 * SET, n);
    check({31'h0, rc_clk_sel}, 32'h0, "main clock back");
    wr(FSW_IRQST_OFS, 32'h7);
  endtask

  task automatic s_regs;
    logic [31:0] r;
    logic        e;
    rd(FSW_RELOAD_OFS, r);
    check(r, {25'h0, RELOAD_RST}, "reload reset");
    wr(FSW_RELOAD_OFS, 32'hFFFF_FFFF);
    rd(FSW_RELOAD_OFS, r);
    check(r, 32'h7F, "reload width");
    rd(FSW_COUNT_OFS, r);
    check(r, 32'h0, "count clear");
    rd(FSW_STATUS_OFS, r);
    check(r & 32'h3, 32'h0, "stopped, no cause");
    apb(1'b0, 8'h40, 32'h0, r, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    check(r, 32'h0, "unmapped reads 0");
  endtask

  task automatic s_refresh;
    logic [31:0] r;
    wr(FSW_CTRL_OFS, 32'h2);
    rd(FSW_STATUS_OFS, r);
    check(r & 32'h2, 32'h2, "running");
    wr(FSW_CTRL_OFS, 32'h1);
    wr(FSW_CTRL_OFS, 32'h2);
    rd(FSW_COUNT_OFS, r);
    check(r & 32'h7F00, 32'h7F00, "refresh loads reload");
    wr(FSW_RELOAD_OFS, 32'h0);
    wr(FSW_CTRL_OFS, 32'h1);
    rd(FSW_STATUS_OFS, r);
    wr(FSW_CTRL_OFS, 32'h2);
    wr(FSW_CTRL_OFS, 32'h3);
    wr(FSW_CTRL_OFS, 32'h2);
    rd(FSW_COUNT_OFS, r);
    check(r & 32'h7F00, 32'h7F00, "broken pair ignored");
    wr(FSW_CTRL_OFS, 32'h1);
    wr(FSW_CTRL_OFS, 32'h2);
    rd(FSW_COUNT_OFS, r);
    check(r & 32'h7F00, 32'h0, "refresh to zero");
  endtask

  task automatic s_freeze;
    logic [31:0] d;
    int          n;
    rate(1200, d);
    check({31'h0, d >= 99 && d <= 102}, 32'h1, "divide by 12");
    idle_mode <= 1'b1;
    rate(300, d);
    check(d, 32'h0, "idle freeze");
    idle_mode  <= 1'b0;
    power_down <= 1'b1;
    rate(300, d);
    check(d, 32'h0, "power-down freeze");
    power_down <= 1'b0;
    repeat (3) @(posedge pclk);
    check({31'h0, wake_hold}, 32'h1, "wake wait");
    wait_lvl(wake_hold, 1'b0, 4 * SET, n);
    check({31'h0, n >= SET - 4}, 32'h1, "wake wait length");
  endtask

  task automatic s_overflow;
    logic [31:0] r;
    int          n;
    wr(FSW_IRQMSK_OFS, 32'h1);
    wr(FSW_RELOAD_OFS, 32'h7F);
    wr(FSW_CTRL_OFS, 32'h1);
    wr(FSW_CTRL_OFS, 32'h2);
    check({31'h0, irq_q}, 32'h0, "no early irq");
    wait_lvl(wdt_reset_q, 1'b1, 4000, n);
    check({31'h0, n >= 256 * DIV_FAST - 40}, 32'h1, "not early");
    rd(FSW_STATUS_OFS, r);
    check(r & 32'h3, 32'h1, "cause set, stopped");
    check({31'h0, irq_q}, 32'h1, "overflow irq");
    wr(FSW_IRQMSK_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_q}, 32'h0, "masked irq");
    wr(FSW_IRQST_OFS, 32'h1);
    rd(FSW_IRQST_OFS, r);
    check(r & 32'h1, 32'h0, "status cleared");
    // Rate bit is only accepted while stopped, so set it first
    wr(FSW_CTRL_OFS, 32'h4);
    wr(FSW_CTRL_OFS, 32'h6);
    rate(1920, r);
    check({31'h0, r >= 9 && r <= 12}, 32'h1, "divide by 192");
  endtask

  task automatic s_osc;
    logic [31:0] r;
    int          n;
    wr(FSW_IRQMSK_OFS, 32'h6);
    osc_slow <= 1'b1;
    wait_lvl(osc_reset, 1'b1, 10, n);
    check({31'h0, rc_clk_sel}, 32'h1, "rc clock");
    rd(FSW_STATUS_OFS, r);
    check(r & 32'hC, 32'hC, "status shows monitor hold");
    osc_slow <= 1'b0;
    wait_lvl(rc_clk_sel, 1'b0, 10, n);
    repeat (SET / 2) @(posedge pclk);
    check({31'h0, osc_reset}, 32'h1, "settling hold");
    wait_lvl(osc_reset, 1'b0, 4 * SET, n);
    rd(FSW_IRQST_OFS, r);
    check(r & 32'h6, 32'h6, "osc events");
    check({31'h0, irq_q}, 32'h1, "osc irq");
  endtask

  // Reset in mid-run, then start from the pin
  task automatic s_restart;
    logic [31:0] r;
    do_reset();
    rd(FSW_STATUS_OFS, r);
    check(r & 32'h3, 32'h0, "reset clears cause, stops");
    pin <= 1'b1;
    repeat (8) @(posedge pclk);
    pin <= 1'b0;
    rd(FSW_STATUS_OFS, r);
    check(r & 32'h2, 32'h2, "pin start");
  endtask

  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    pin        = 1'b0;
    idle_mode  = 1'b0;
    power_down = 1'b0;
    osc_slow   = 1'b0;
    bad_count  = 0;
    checked    = 0;
    @(posedge pclk);
    do_reset();
    s_regs();
    s_refresh();
    s_freeze();
    s_overflow();
    s_osc();
    s_restart();
    print_verdict();
  end
endmodule
